/* design/swh_pkg.sv */
// Constants and types for the single-wire identity ROM host controller
package swh_pkg;
  //----------------------------------------------------------------
  // Clock and line timing
  //----------------------------------------------------------------
  localparam int CLK_NS   = 8;      // Period of mclk_in
  localparam int RSTL_NS  = 480000; // reset_low_time, least
  localparam int RSTH_NS  = 480000; // High recovery after reset, least
  localparam int PSAMP_NS = 70000;  // Presence sample after release
  localparam int SLOT_NS  = 70000;  // Whole time slot, least 60 us
  localparam int LOW0_NS  = 64000;  // Write-zero low, least 60 us
  localparam int LOW1_NS  = 6000;   // Write-one and read low, least 1 us
  localparam int RSAMP_NS = 13000;  // Read sample point, longest 15 us
  localparam int REC_NS   = 2000;   // Idle gap between slots, least 1 us
  //----------------------------------------------------------------
  // Cycle counts: least times round up, longest times round down
  //----------------------------------------------------------------
  localparam int RSTL_CYC  = (RSTL_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSTH_CYC  = (RSTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PSAMP_CYC = PSAMP_NS / CLK_NS;
  localparam int SLOT_CYC  = (SLOT_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOW0_CYC  = (LOW0_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOW1_CYC  = (LOW1_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSAMP_CYC = RSAMP_NS / CLK_NS;
  localparam int REC_CYC   = (REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W     = 17;    // Width of the timing counter
  //----------------------------------------------------------------
  // ROM commands, sizes and phase codes
  //----------------------------------------------------------------
  localparam logic [7:0] OP_READ_A = 8'h33; // Identity read
  localparam logic [7:0] OP_READ_B = 8'h0F; // Identity read, legacy code
  localparam logic [7:0] OP_SKIP   = 8'hCC; // Skip, device stays silent
  localparam logic [7:0] OP_SEARCH = 8'hF0; // Search
  localparam logic [1:0] CMD_READ_A = 2'h0; // User command codes
  localparam logic [1:0] CMD_READ_B = 2'h1;
  localparam logic [1:0] CMD_SKIP   = 2'h2;
  localparam logic [1:0] CMD_SEARCH = 2'h3;
  localparam logic [6:0] LAST_BIT  = 7'h3F; // Last of 64 ROM bits
  localparam logic [6:0] LAST_CMD  = 7'h07; // Last of 8 command bits
  localparam int BYTE_W     = 8;    // FIFO word width
  localparam int FIFO_DEPTH = 16;   // FIFO depth
  localparam logic [1:0] PH_CMD  = 2'h0; // Sending the command byte
  localparam logic [1:0] PH_READ = 2'h1; // Reading 64 ROM bits
  localparam logic [1:0] PH_SRCH = 2'h2; // Search triplets
  //----------------------------------------------------------------
  // Controller states
  //----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01, // Line released, ready for a command
    ST_RLOW  = 5'h02, // Driving the reset pulse
    ST_RHIGH = 5'h04, // Released, presence and recovery
    ST_GAP   = 5'h08, // Released between slots
    ST_SLOT  = 5'h10  // Inside a time slot
  } swh_state_t;
endpackage

/* design/swh_host.sv */
// Single-wire identity ROM host controller with its result FIFO
`timescale 1ns/1ns

//------------------------------------------------------------------
// FIFO with registered output stage
//------------------------------------------------------------------
module swh_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(D);
  localparam int CW = AW + 1;
  logic [W-1:0]  mem_q [D];  // Storage
  logic [AW-1:0] wp_q;       // Write pointer
  logic [AW-1:0] rp_q;       // Read pointer
  logic [CW-1:0] cnt_q;      // Words held in storage
  logic          wr;         // Write accepted
  logic          ld;         // Move a word to the output stage

  assign in_ready_out = (cnt_q != CW'(D));
  assign wr = in_valid_in && in_ready_out;
  assign ld = (cnt_q != '0) && (!out_valid_out || out_ready_in);

  // Storage write, no reset needed
  always_ff @(posedge clk_in) begin
    if (wr) begin
      mem_q[wp_q] <= in_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr) begin
        wp_q <= wp_q + AW'(1);
      end
      if (ld) begin
        rp_q <= rp_q + AW'(1);
      end
      cnt_q <= cnt_q + CW'(wr) - CW'(ld);
    end
  end

  // Output stage, holds until taken
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (ld) begin
      out_valid_out <= 1'b1;
      out_data_out  <= mem_q[rp_q];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end
endmodule

//------------------------------------------------------------------
// Host controller top
//------------------------------------------------------------------
module swh_host import swh_pkg::*; #(
  parameter int RSTL_CYC_P  = RSTL_CYC,
  parameter int RSTH_CYC_P  = RSTH_CYC,
  parameter int PSAMP_CYC_P = PSAMP_CYC,
  parameter int SLOT_CYC_P  = SLOT_CYC,
  parameter int LOW0_CYC_P  = LOW0_CYC,
  parameter int LOW1_CYC_P  = LOW1_CYC,
  parameter int RSAMP_CYC_P = RSAMP_CYC,
  parameter int REC_CYC_P   = REC_CYC
) (
  input  wire logic       mclk_in,
  input  wire logic       rstn_in,
  input  wire logic       cmd_valid_in,
  input  wire logic [1:0] cmd_code_in,
  output logic            cmd_ready_out,
  output logic            done_out,
  output logic            presence_out,
  output logic            error_out,
  output logic            rom_valid_out,
  output logic [7:0]      rom_data_out,
  input  wire logic       rom_ready_in,
  input  wire logic       dq_in,
  output logic            dq_out,
  output logic            dq_oe_n_out
);
  localparam logic [CNT_W-1:0] RSTL_END  = CNT_W'(RSTL_CYC_P - 1);
  localparam logic [CNT_W-1:0] RSTH_END  = CNT_W'(RSTH_CYC_P - 1);
  localparam logic [CNT_W-1:0] PSAMP_END = CNT_W'(PSAMP_CYC_P - 1);
  localparam logic [CNT_W-1:0] SLOT_END  = CNT_W'(SLOT_CYC_P - 1);
  localparam logic [CNT_W-1:0] LOW0_END  = CNT_W'(LOW0_CYC_P - 1);
  localparam logic [CNT_W-1:0] LOW1_END  = CNT_W'(LOW1_CYC_P - 1);
  localparam logic [CNT_W-1:0] RSAMP_END = CNT_W'(RSAMP_CYC_P - 1);
  localparam logic [CNT_W-1:0] REC_END   = CNT_W'(REC_CYC_P - 1);

  swh_state_t       st_q;       // Controller state
  logic [CNT_W-1:0] cnt_q;      // Cycles spent in the state
  logic             dq_s1_q;    // Line synchroniser, first stage
  logic             dq_s2_q;    // Line synchroniser, second stage
  logic [1:0]       op_q;       // Accepted user command
  logic [7:0]       cmd_q;      // Opcode put on the line
  logic [1:0]       phase_q;    // Transaction phase
  logic [6:0]       bitn_q;     // Bit index in the phase
  logic [1:0]       sub_q;      // Search triplet step
  logic             id_q;       // Search: ROM bit read
  logic             cmp_q;      // Search: complement read
  logic             rx_q;       // Level sampled in the slot
  logic             slot_bit_q; // Bit sent in the slot, 1 for reads
  logic [7:0]       sh_q;       // Byte assembly, LSB first
  logic             push_q;     // Byte ready for the FIFO
  logic [7:0]       push_byte_q; // Byte handed to the FIFO
  logic             fifo_rdy;   // FIFO has room
  logic             accept;     // Command taken
  logic             go_slot;    // Slot starts
  logic             slot_end;   // Slot ends
  logic [1:0]       nx_phase;   // Next phase after the slot
  logic [6:0]       nx_bitn;    // Next bit index
  logic [1:0]       nx_sub;     // Next triplet step
  logic             fin;        // Transaction finishes
  logic             bad;        // Search found no device
  logic             push;       // Slot yields a result bit
  logic             push_bit;   // Result bit
  logic             nx_bit;     // Bit for the next slot

  assign accept   = (st_q == ST_IDLE) && cmd_valid_in;
  // Stall before a slot while the FIFO cannot take a byte
  assign go_slot  = (st_q == ST_GAP) && (cnt_q >= REC_END) && fifo_rdy && !push_q;
  assign slot_end = (st_q == ST_SLOT) && (cnt_q == SLOT_END);

  //----------------------------------------------------------------
  // Line input synchroniser
  //----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dq_s1_q <= 1'b1;
      dq_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  //----------------------------------------------------------------
  // Bookkeeping at the end of each slot
  //----------------------------------------------------------------
  always_comb begin
    nx_phase = phase_q;
    nx_bitn  = bitn_q + 7'h01;
    nx_sub   = sub_q;
    fin      = 1'b0;
    bad      = 1'b0;
    push     = 1'b0;
    push_bit = rx_q;
    case (phase_q)
      PH_CMD: begin // Eight command bits, then branch
        if (bitn_q == LAST_CMD) begin
          nx_bitn = 7'h00;
          case (op_q)
            CMD_SEARCH: nx_phase = PH_SRCH;
            CMD_SKIP:   fin = 1'b1; // Nothing follows a skip
            default:    nx_phase = PH_READ; // Read assumes one device
          endcase
        end
      end
      PH_READ: begin // 64 read slots
        push = 1'b1;
        fin  = (bitn_q == LAST_BIT);
      end
      PH_SRCH: begin // Bit, complement, chosen bit
        nx_bitn = bitn_q;
        if (sub_q == 2'h0) begin
          nx_sub = 2'h1;
        end else if (sub_q == 2'h1) begin
          nx_sub = 2'h2;
          bad    = id_q & rx_q; // Both ones: nobody answers
          fin    = bad;
        end else begin
          nx_sub   = 2'h0;
          push     = 1'b1;
          push_bit = slot_bit_q;
          nx_bitn  = bitn_q + 7'h01;
          fin      = (bitn_q == LAST_BIT);
        end
      end
      default: fin = 1'b1;
    endcase
  end

  // Bit for the next slot; reads leave the line to the device
  always_comb begin
    case (phase_q)
      PH_CMD:  nx_bit = cmd_q[bitn_q[2:0]]; // LSB first
      PH_SRCH: nx_bit = (sub_q == 2'h2) ? ((id_q ^ cmp_q) & id_q) : 1'b1;
      default: nx_bit = 1'b1;
    endcase
  end

  //----------------------------------------------------------------
  // State and timing counter
  //----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q  <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
      case (st_q)
        ST_IDLE: begin // Host opens every transaction
          cnt_q <= '0;
          if (accept) begin
            st_q <= ST_RLOW;
          end
        end
        ST_RLOW: begin // Reset pulse length
          if (cnt_q == RSTL_END) begin
            st_q  <= ST_RHIGH;
            cnt_q <= '0;
          end
        end
        ST_RHIGH: begin // Full recovery before any slot
          if (cnt_q == RSTH_END) begin
            st_q  <= presence_out ? ST_GAP : ST_IDLE;
            cnt_q <= '0;
          end
        end
        ST_GAP: begin // Line idles high between slots
          if (go_slot) begin
            st_q  <= ST_SLOT;
            cnt_q <= '0;
          end else if (cnt_q >= REC_END) begin
            cnt_q <= cnt_q;
          end
        end
        ST_SLOT: begin // Slot plus gap bounds the rate
          if (slot_end) begin
            st_q  <= fin ? ST_IDLE : ST_GAP;
            cnt_q <= '0;
          end
        end
        default: begin
          st_q  <= ST_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  //----------------------------------------------------------------
  // Line driver: open drain, data pin always low
  //----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dq_oe_n_out <= 1'b1;
      dq_out      <= 1'b0;
      slot_bit_q  <= 1'b1;
      rx_q        <= 1'b1;
    end else begin
      if (accept || go_slot) begin // Every slot opens low
        dq_oe_n_out <= 1'b0;
      end else if ((st_q == ST_RLOW) && (cnt_q == RSTL_END)) begin
        dq_oe_n_out <= 1'b1;
      end else if ((st_q == ST_SLOT) && (cnt_q == (slot_bit_q ? LOW1_END : LOW0_END))) begin
        dq_oe_n_out <= 1'b1;
      end
      if (go_slot) begin
        slot_bit_q <= nx_bit;
      end
      if ((st_q == ST_SLOT) && (cnt_q == RSAMP_END)) begin
        rx_q <= dq_s2_q; // Inside the device's valid window
      end
    end
  end

  //----------------------------------------------------------------
  // Transaction progress, status and result bytes
  //----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      op_q <= CMD_READ_A;
      cmd_q <= OP_READ_A;
      phase_q <= PH_CMD;
      bitn_q <= '0;
      sub_q <= '0;
      id_q <= 1'b0;
      cmp_q <= 1'b0;
      sh_q <= '0;
      push_q <= 1'b0;
      push_byte_q <= '0;
      cmd_ready_out <= 1'b1;
      done_out <= 1'b0;
      presence_out <= 1'b0;
      error_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      push_q   <= 1'b0;
      if (accept) begin // Fresh transaction
        op_q          <= cmd_code_in;
        phase_q       <= PH_CMD;
        bitn_q        <= '0;
        sub_q         <= '0;
        cmd_ready_out <= 1'b0;
        presence_out  <= 1'b0;
        error_out     <= 1'b0;
        case (cmd_code_in)
          CMD_READ_B: cmd_q <= OP_READ_B;
          CMD_SKIP:   cmd_q <= OP_SKIP;
          CMD_SEARCH: cmd_q <= OP_SEARCH;
          default:    cmd_q <= OP_READ_A;
        endcase
      end
      if ((st_q == ST_RHIGH) && (cnt_q == PSAMP_END) && !dq_s2_q) begin
        presence_out <= 1'b1; // Presence seen
      end
      if ((st_q == ST_RHIGH) && (cnt_q == RSTH_END) && !presence_out) begin
        error_out     <= 1'b1; // No device answered
        done_out      <= 1'b1;
        cmd_ready_out <= 1'b1;
      end
      if (slot_end) begin
        phase_q <= nx_phase;
        bitn_q  <= nx_bitn;
        sub_q   <= nx_sub;
        if ((phase_q == PH_SRCH) && (sub_q == 2'h0)) begin
          id_q <= rx_q;
        end
        if ((phase_q == PH_SRCH) && (sub_q == 2'h1)) begin
          cmp_q <= rx_q;
        end
        if (push) begin // Bytes assembled LSB first
          sh_q <= {push_bit, sh_q[7:1]};
          if (bitn_q[2:0] == 3'h7) begin
            push_q <= 1'b1;
            push_byte_q <= {push_bit, sh_q[7:1]};
          end
        end
        if (bad) begin
          error_out <= 1'b1;
        end
        if (fin) begin
          done_out      <= 1'b1;
          cmd_ready_out <= 1'b1;
        end
      end
    end
  end

  //----------------------------------------------------------------
  // Result FIFO
  //----------------------------------------------------------------
  swh_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
    .clk_in        (mclk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (push_q),
    .in_ready_out  (fifo_rdy),
    .in_data_in    (push_byte_q),
    .out_valid_out (rom_valid_out),
    .out_ready_in  (rom_ready_in),
    .out_data_out  (rom_data_out)
  );

  //----------------------------------------------------------------
  // Assertions and their helper counters
  //----------------------------------------------------------------
  logic [CNT_W-1:0] drv_cnt_q; // Cycles the line has been driven
  logic [CNT_W-1:0] hi_cnt_q;  // Cycles the line has been released
  logic [CNT_W-1:0] sp_cnt_q;  // Cycles since the last slot start

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      drv_cnt_q <= '0;
      hi_cnt_q  <= '1;
      sp_cnt_q  <= '1;
    end else begin
      drv_cnt_q <= dq_oe_n_out ? '0 : drv_cnt_q + CNT_W'(1);
      hi_cnt_q  <= !dq_oe_n_out ? '0 : (&hi_cnt_q ? hi_cnt_q : hi_cnt_q + CNT_W'(1));
      sp_cnt_q  <= go_slot ? '0 : (&sp_cnt_q ? sp_cnt_q : sp_cnt_q + CNT_W'(1));
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  sequence slot_start_s;
    $rose(st_q == ST_SLOT);
  endsequence
  sequence reset_end_s;
    $rose(dq_oe_n_out) ##0 $past(st_q) == ST_RLOW;
  endsequence

  AST_RESET_LEN: assert property (reset_end_s |-> drv_cnt_q >= RSTL_CYC_P)
    else $error("reset pulse shorter than required");
  AST_SLOT_OPENS_LOW: assert property (slot_start_s |-> !dq_oe_n_out ##1 !dq_oe_n_out)
    else $error("slot did not open with the line pulled low");
  AST_OPEN_DRAIN: assert property (dq_out == 1'b0)
    else $error("line data driven high");
  AST_HOST_ONLY_DRIVES: assert property (!dq_oe_n_out |-> st_q inside {ST_RLOW, ST_SLOT})
    else $error("line driven outside reset or slot");
  AST_IDLE_RELEASED: assert property (st_q inside {ST_IDLE, ST_GAP} |-> dq_oe_n_out)
    else $error("line not released while idle");
  AST_RATE: assert property (slot_start_s |-> $past(sp_cnt_q) >= SLOT_CYC_P + REC_CYC_P - 1)
    else $error("slots too close together");
  AST_PRESENCE_FIRST: assert property (slot_start_s |-> presence_out)
    else $error("slot started without presence");
  AST_CMD_LSB_FIRST: assert property (
    slot_start_s ##0 (phase_q == PH_CMD && bitn_q == 7'h00) |-> slot_bit_q == cmd_q[0])
    else $error("command not sent LSB first");
  AST_CMD_EIGHT: assert property (
    $past(phase_q) == PH_CMD && phase_q != PH_CMD |-> $past(bitn_q) == LAST_CMD)
    else $error("command phase not eight bits");
  AST_RECOVERY: assert property (
    slot_start_s ##0 (phase_q == PH_CMD && bitn_q == 7'h00) |-> $past(hi_cnt_q) >= RSTH_CYC_P)
    else $error("slot before reset recovery elapsed");
  AST_SEARCH_CHOICE: assert property (
    slot_start_s ##0 (phase_q == PH_SRCH && sub_q == 2'h2)
    |-> slot_bit_q == ((id_q != cmp_q) ? id_q : 1'b0))
    else $error("search wrote a bit against the read pair");
endmodule

/* design/swh_unused_placeholder_none.sv */
// Intentionally empty: no further design content
`timescale 1ns/1ns

/* verification/swh_dev_model.sv */
// Behavioural single-wire identity ROM device answering the host controller
`timescale 1ns/1ns

module swh_dev_model import swh_pkg::*; #(
  parameter logic [63:0] ROM_P   = 64'hC3_9A5E17D2486B_5A, // Family byte 5A is arbitrary
  parameter int          RST_NS  = 20000,  // Low longer than this counts as reset
  parameter int          PDH_NS  = 2000,   // presence_wait_time
  parameter int          PDL_NS  = 12000,  // presence_low_time
  parameter int          SAMP_NS = 8000,   // Write sample point after the fall
  parameter int          HOLD_NS = 13400   // Zero hold time in a read slot
) (
  input  wire logic       line_in,    // Resolved line level
  input  wire logic       enable_in,  // Device present on the line
  output logic            pull_n_out, // Low while pulling the line down
  output logic [7:0]      cmd_out     // Last command byte received
);
  //----------------------------------------------------------------
  // Slot state
  //----------------------------------------------------------------
  localparam int M_OFF = 0; // Silent until the next reset
  localparam int M_CMD = 1; // Taking command bits
  localparam int M_RD  = 2; // Sending the ROM
  localparam int M_SR  = 3; // Search triplets
  int   mode  = M_OFF; // Current phase
  int   idx   = 0;     // ROM bit index
  int   ph    = 0;     // Step inside a search triplet
  int   cnt   = 0;     // Command bits taken
  time  t_fall = 0;    // Time of the last falling edge
  logic b;             // Bit sent or sampled
  bit   in_pres = 1'b0; // Own presence pulse running

  initial begin
    pull_n_out = 1'b1;
    cmd_out    = 8'h00;
  end

  // Command decode: unknown, match and skip all go silent
  function automatic int decode(input logic [7:0] op);
    case (op)
      OP_READ_A, OP_READ_B: return M_RD;
      OP_SEARCH:            return M_SR;
      default:              return M_OFF;
    endcase
  endfunction

  // End of a long low: restart and answer with presence
  always @(posedge line_in) begin
    if (enable_in && !in_pres && ($time - t_fall) > RST_NS) begin
      mode    = M_CMD;
      idx     = 0;
      ph      = 0;
      cnt     = 0;
      in_pres = 1'b1;
      #(PDH_NS) pull_n_out = 1'b0;
      #(PDL_NS) t_fall = $time;
      pull_n_out = 1'b1;
      in_pres    = 1'b0;
    end
  end

  // Each host fall opens a slot and starts the internal delay
  always @(negedge line_in) begin
    if (enable_in && !in_pres) begin
      t_fall = $time;
      if (mode == M_RD || (mode == M_SR && ph < 2)) begin
        b = ROM_P[idx] ^ (ph == 1);
        if (mode == M_SR) ph = ph + 1;
        else idx = idx + 1;
        if (idx == 64) mode = M_OFF;
        if (!b) begin
          pull_n_out = 1'b0;
          #(HOLD_NS) pull_n_out = 1'b1;
        end
      end else if (mode == M_CMD || mode == M_SR) begin
        #(SAMP_NS) b = line_in;
        if (mode == M_CMD) begin
          cmd_out[cnt] = b;
          cnt = cnt + 1;
          if (cnt == 8) mode = decode(cmd_out);
        end else begin
          if (b !== ROM_P[idx]) mode = M_OFF;
          idx = idx + 1;
          ph  = 0;
          if (idx == 64) mode = M_OFF;
        end
      end
    end
  end
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the single-wire host controller and its FIFO
`timescale 1ns/1ns

module tb_top import swh_pkg::*; ;
  //----------------------------------------------------------------
  // Signals and instances
  //----------------------------------------------------------------
  localparam logic [63:0] ROM = 64'hC3_9A5E17D2486B_5A; // Same arbitrary ROM as the model
  typedef struct packed {
    logic [1:0] code; // Command code
    logic       dev;  // Device present
    logic       pres; // Expected presence flag
    logic       err;  // Expected error flag
    logic [7:0] op;   // Expected opcode on the line
  } swh_row_t;
  swh_row_t rows [2] = '{'{CMD_SKIP, 1'b1, 1'b1, 1'b0, OP_SKIP},
                         '{CMD_READ_A, 1'b0, 1'b0, 1'b1, 8'h00}};
  logic       mclk_in      = 1'b0;
  logic       rstn_in      = 1'b0;
  logic       cmd_valid_in = 1'b0;
  logic [1:0] cmd_code_in  = 2'h0;
  logic       rom_ready_in = 1'b0;
  logic       dev_en       = 1'b1; // Device attached
  logic       cmd_ready_out, done_out, presence_out, error_out, rom_valid_out;
  logic       dq_out, dq_oe_n_out, dev_pull_n;
  logic [7:0] rom_data_out, dev_cmd;
  logic [7:0] got [$];             // Bytes taken from the FIFO
  int         miscompares = 0;
  int         n_tests     = 0;
  wire        line = (dq_oe_n_out ? 1'b1 : dq_out) & dev_pull_n; // Pull-up, wired-AND

  // Shortened line timing keeps the run short; the model is scaled to match
  swh_host #(.RSTL_CYC_P(400), .RSTH_CYC_P(400), .PSAMP_CYC_P(100), .SLOT_CYC_P(120),
    .LOW0_CYC_P(110), .LOW1_CYC_P(20), .RSAMP_CYC_P(80), .REC_CYC_P(10))
    i_swh_host (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in), .cmd_ready_out(cmd_ready_out),
    .done_out(done_out), .presence_out(presence_out), .error_out(error_out),
    .rom_valid_out(rom_valid_out), .rom_data_out(rom_data_out), .rom_ready_in(rom_ready_in),
    .dq_in(line), .dq_out(dq_out), .dq_oe_n_out(dq_oe_n_out));
  swh_dev_model #(.ROM_P(ROM), .RST_NS(2000), .PDH_NS(200), .PDL_NS(1200), .SAMP_NS(400),
    .HOLD_NS(800)) i_swh_dev_model (.line_in(line), .enable_in(dev_en),
    .pull_n_out(dev_pull_n), .cmd_out(dev_cmd));

  always #4 mclk_in = ~mclk_in;

  // Consumer side of the FIFO
  always @(posedge mclk_in) begin
    if (rom_valid_out === 1'b1 && rom_ready_in === 1'b1) got.push_back(rom_data_out);
  end

  //----------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Bounded wait for the end-of-transaction pulse
  task automatic wait_done();
    int n;
    n = 0;
    while (done_out !== 1'b1 && n < 40000) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    check(64'(n < 40000), 64'h1);
  endtask

  // Hold the request until the edge that takes it
  task automatic run_cmd(input logic [1:0] code, input bit wait_end);
    @(negedge mclk_in);
    cmd_valid_in = 1'b1;
    cmd_code_in  = code;
    do @(posedge mclk_in); while (cmd_ready_out !== 1'b1);
    @(negedge mclk_in);
    cmd_valid_in = 1'b0;
    if (wait_end) wait_done();
  endtask

  // FIFO contents against repeated ROM images, family byte first
  task automatic check_bytes(input int n);
    check(64'(got.size()), 64'(n));
    for (int i = 0; i < got.size() && i < n; i++) check(got[i], ROM[8*(i%8) +: 8]);
    got.delete();
  endtask

  //----------------------------------------------------------------
  // Main sequence and watchdog
  //----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge mclk_in);
    check(cmd_ready_out, 1'b1);
    check(dq_oe_n_out, 1'b1);
    check(done_out, 1'b0);
    check(rom_valid_out, 1'b0);
    rstn_in      = 1'b1;
    rom_ready_in = 1'b1;
    // Table rows: skip with device, read with nobody present
    foreach (rows[i]) begin
      dev_en = rows[i].dev;
      run_cmd(rows[i].code, 1'b1);
      check(presence_out, rows[i].pres);
      check(error_out, rows[i].err);
      if (rows[i].dev) check(dev_cmd, rows[i].op);
      repeat (20) @(negedge mclk_in);
      check_bytes(0);
    end
    // Two reads leave the FIFO one byte short of full; a search fills it and stalls
    dev_en       = 1'b1;
    rom_ready_in = 1'b0;
    run_cmd(CMD_READ_B, 1'b1);
    check(dev_cmd, OP_READ_B);
    run_cmd(CMD_READ_A, 1'b1);
    check(dev_cmd, OP_READ_A);
    run_cmd(CMD_SEARCH, 1'b0);
    repeat (10000) @(negedge mclk_in);
    check(line, 1'b1);
    check(cmd_ready_out, 1'b0);
    rom_ready_in = 1'b1;
    wait_done();
    check(error_out, 1'b0);
    check(dev_cmd, OP_SEARCH);
    repeat (40) @(negedge mclk_in);
    check_bytes(24);
    // Device drops out in a search: both reads high end it
    run_cmd(CMD_SEARCH, 1'b0);
    repeat (3000) @(negedge mclk_in);
    dev_en = 1'b0;
    wait_done();
    check(error_out, 1'b1);
    check(presence_out, 1'b1);
    check_bytes(0);
    dev_en = 1'b1;
    // Reset in mid-read: line freed, controller idle again
    run_cmd(CMD_READ_A, 1'b0);
    repeat (3000) @(negedge mclk_in);
    rstn_in = 1'b0;
    @(negedge mclk_in);
    check(dq_oe_n_out, 1'b1);
    check(cmd_ready_out, 1'b1);
    check(presence_out, 1'b0);
    rstn_in = 1'b1;
    got.delete();
    run_cmd(CMD_SKIP, 1'b1);
    check(presence_out, 1'b1);
    check(dev_cmd, OP_SKIP);
    test_done();
  end

  // About 65k cycles of traffic; cut off at 100k cycles
  initial begin
    #(800_000);
    miscompares++;
    test_done();
  end
endmodule
